//--- design/blank_pkg.sv
// constants for the display blanking timing block
// assumes a 32-bit classic wishbone slave on the pixel clock
package blank_pkg;
   localparam logic [7:0]  HBLANK_OFS   = 8'h00;
   localparam logic [7:0]  VBLANK_OFS   = 8'h04;
   localparam logic [7:0]  MODE_OFS     = 8'h08;
   localparam logic [7:0]  FRAME_OFS    = 8'h0C;
   localparam logic [7:0]  VBIT_OFS     = 8'h10;
   localparam logic [7:0]  STATUS_OFS   = 8'h14;
   localparam logic [31:0] HBLANK_MASK  = 32'h0FFF8FFF;
   localparam logic [31:0] POS_MASK     = 32'h0FFF0FFF;
   localparam logic [31:0] MODE_MASK    = 32'h00000007;
   localparam logic [31:0] VBIT_MASK    = 32'h00000001;
   localparam logic [31:0] REG_RESET    = 32'h00000000;
   localparam int          HI_LSB       = 16;
   localparam int          DELAY_BIT    = 15;
   localparam int          RAW_BIT      = 1;
   localparam logic [2:0]  DELAY_CLOCKS = 3'h4;
   localparam logic [11:0] PIX_FIRST    = 12'h000;
   localparam logic [11:0] LINE_FIRST   = 12'h001;
   typedef enum logic [1:0] {LB_ACTIVE, LB_BLANK, LB_HOLD} line_state_t;
endpackage

//--- design/display_blanking_timing.sv
// display blanking timing: line/frame blank, code insertion strobes
// assumes a classic wishbone master on CORE_CLK, the pixel clock
`timescale 1ns/1ps
module display_blanking_timing
   import blank_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             LINE_BLANK,
   output logic             FRAME_BLANK,
   output logic             EAV_INSERT,
   output logic             SAV_INSERT,
   output logic             FIELD1_VBIT
);

   // byte-lane write with reserved bits forced to zero
   function automatic logic [31:0] lane_write(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0]  sel,
      input logic [31:0] mask
   );
      logic [31:0] be;
      be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return ((old & ~be) | (data & be)) & mask;
   endfunction

   logic [31:0] display_horizontal_blank_positions;
   logic [31:0] display_field1_vertical_blank_start;
   logic [31:0] mode_reg;
   logic [31:0] frame_size_reg;
   logic [31:0] f1_vbit_control_reg;
   logic [31:0] next_hblank;
   logic [31:0] next_vblank;
   logic [31:0] next_mode;
   logic [31:0] next_frame;
   logic [31:0] next_vbit;
   logic [31:0] next_dat;
   logic        next_ack;
   logic        wr_go;

   logic [11:0] pixel_position_counter;
   logic [11:0] line_position_counter;
   logic [11:0] next_pix;
   logic [11:0] next_line;
   logic [11:0] frame_pixel_total;
   logic [11:0] frame_line_total;
   logic        line_end;
   logic        frame_end;

   logic [11:0] line_blank_begin;
   logic [11:0] line_blank_end;
   logic        line_blank_delay_en;
   logic [11:0] f1_vblank_begin_line;
   logic [11:0] f1_vblank_begin_pixel;
   logic        raw_mode;
   logic        hit_begin;
   logic        hit_end;

   line_state_t line_state;
   line_state_t next_line_state;
   logic [2:0]  delay_cnt;
   logic [2:0]  next_delay_cnt;
   logic        next_line_blank;
   logic        next_frame_blank;
   logic        next_eav;
   logic        next_sav;
   logic        next_field1_vbit;

   // field views of the registers
   always_comb
   begin
      line_blank_begin      = display_horizontal_blank_positions[11:0];
      line_blank_end        = display_horizontal_blank_positions[HI_LSB +: 12];
      line_blank_delay_en   = display_horizontal_blank_positions[DELAY_BIT];
      f1_vblank_begin_pixel = display_field1_vertical_blank_start[11:0];
      f1_vblank_begin_line  = display_field1_vertical_blank_start[HI_LSB +: 12];
      frame_pixel_total     = frame_size_reg[11:0];
      frame_line_total      = frame_size_reg[HI_LSB +: 12];
      raw_mode              = mode_reg[RAW_BIT];
   end

   // wishbone slave: one wait state, ack for one cycle
   always_comb
   begin
      wr_go       = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
      next_ack    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
      next_hblank = display_horizontal_blank_positions;
      next_vblank = display_field1_vertical_blank_start;
      next_mode   = mode_reg;
      next_frame  = frame_size_reg;
      next_vbit   = f1_vbit_control_reg;
      next_dat    = 32'h00000000;
      if (wr_go)
      begin
         case (WB_ADR_I)
            HBLANK_OFS: next_hblank = lane_write(next_hblank, WB_DAT_I, WB_SEL_I,
                                                 HBLANK_MASK);
            VBLANK_OFS: next_vblank = lane_write(next_vblank, WB_DAT_I, WB_SEL_I,
                                                 POS_MASK);
            MODE_OFS:   next_mode = lane_write(next_mode, WB_DAT_I, WB_SEL_I,
                                               MODE_MASK);
            FRAME_OFS:  next_frame = lane_write(next_frame, WB_DAT_I, WB_SEL_I,
                                                POS_MASK);
            VBIT_OFS:   next_vbit = lane_write(next_vbit, WB_DAT_I, WB_SEL_I,
                                               VBIT_MASK);
            default:    next_dat = 32'h00000000;
         endcase
      end
      if (next_ack && !WB_WE_I)
      begin
         case (WB_ADR_I)
            HBLANK_OFS: next_dat = display_horizontal_blank_positions;
            VBLANK_OFS: next_dat = display_field1_vertical_blank_start;
            MODE_OFS:   next_dat = mode_reg;
            FRAME_OFS:  next_dat = frame_size_reg;
            VBIT_OFS:   next_dat = f1_vbit_control_reg;
            STATUS_OFS: next_dat = {4'h0, line_position_counter, LINE_BLANK,
                                    FRAME_BLANK, 2'h0, pixel_position_counter};
            default:    next_dat = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         display_horizontal_blank_positions  <= REG_RESET;
         display_field1_vertical_blank_start <= REG_RESET;
         mode_reg                            <= REG_RESET;
         frame_size_reg                      <= REG_RESET;
         f1_vbit_control_reg                 <= REG_RESET;
         WB_DAT_O                            <= REG_RESET;
         WB_ACK_O                            <= 1'b0;
      end
      else
      begin
         display_horizontal_blank_positions  <= next_hblank;
         display_field1_vertical_blank_start <= next_vblank;
         mode_reg                            <= next_mode;
         frame_size_reg                      <= next_frame;
         f1_vbit_control_reg                 <= next_vbit;
         WB_DAT_O                            <= next_dat;
         WB_ACK_O                            <= next_ack;
      end
   end

   // frame counters
   always_comb
   begin
      line_end  = (frame_pixel_total == 12'h000) ||
                  (pixel_position_counter >= frame_pixel_total - 12'h001);
      frame_end = line_end && (line_position_counter >= frame_line_total);
      next_pix  = line_end ? PIX_FIRST : pixel_position_counter + 12'h001;
      next_line = line_position_counter;
      if (line_end)
      begin
         next_line = frame_end ? LINE_FIRST : line_position_counter + 12'h001;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         pixel_position_counter <= PIX_FIRST;
         line_position_counter  <= LINE_FIRST;
      end
      else
      begin
         pixel_position_counter <= next_pix;
         line_position_counter  <= next_line;
      end
   end

   // frame blank: set at field-1 start, cleared at frame wrap, set wins
   always_comb
   begin
      next_frame_blank = FRAME_BLANK;
      if (frame_end)
      begin
         next_frame_blank = 1'b0;
      end
      if ((line_position_counter == f1_vblank_begin_line) &&
          (pixel_position_counter == f1_vblank_begin_pixel))
      begin
         next_frame_blank = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         FRAME_BLANK <= 1'b0;
      end
      else
      begin
         FRAME_BLANK <= next_frame_blank;
      end
   end

   // code insertion strobes and field-1 v bit
   always_comb
   begin
      next_eav         = hit_begin && !raw_mode;
      next_sav         = hit_end && !raw_mode;
      next_field1_vbit = f1_vbit_control_reg[0];
   end

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         EAV_INSERT  <= 1'b0;
         SAV_INSERT  <= 1'b0;
         FIELD1_VBIT <= 1'b0;
      end
      else
      begin
         EAV_INSERT  <= next_eav;
         SAV_INSERT  <= next_sav;
         FIELD1_VBIT <= next_field1_vbit;
      end
   end

   // line blank state and delay
   always_comb
   begin
      hit_begin        = (pixel_position_counter == line_blank_begin);
      hit_end          = (pixel_position_counter == line_blank_end);
      next_line_state  = line_state;
      next_delay_cnt   = delay_cnt;
      case (line_state)
         LB_ACTIVE:
         begin
            if (hit_begin)
            begin
               next_line_state = LB_BLANK;
            end
         end
         LB_BLANK:
         begin
            if (hit_end && line_blank_delay_en && !raw_mode)
            begin
               next_line_state = LB_HOLD;
               next_delay_cnt  = DELAY_CLOCKS;
            end
            else if (hit_end)
            begin
               next_line_state = LB_ACTIVE;
            end
         end
         LB_HOLD:
         begin
            next_delay_cnt = delay_cnt - 3'h1;
            if (delay_cnt == 3'h1)
            begin
               next_line_state = LB_ACTIVE;
            end
         end
         default:
         begin
            next_line_state = LB_ACTIVE;
         end
      endcase
      if (hit_begin)
      begin
         next_line_state = LB_BLANK;
      end
      next_line_blank = (next_line_state != LB_ACTIVE);
   end

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         line_state  <= LB_ACTIVE;
         delay_cnt   <= 3'h0;
         LINE_BLANK  <= 1'b0;
      end
      else
      begin
         line_state  <= next_line_state;
         delay_cnt   <= next_delay_cnt;
         LINE_BLANK  <= next_line_blank;
      end
   end

endmodule

//--- tb/blanking_props.sv
// assertions on the blanking block ports
// assumes the bind below reaches every instance
`timescale 1ns/1ps
module blanking_props
   import blank_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RESET,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        LINE_BLANK,
   input wire logic        FRAME_BLANK,
   input wire logic        EAV_INSERT,
   input wire logic        SAV_INSERT,
   input wire logic        FIELD1_VBIT
);
   logic raw_q;
   logic next_raw;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   sequence req_s;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence vbit_wr_s;
      req_s ##0 (WB_WE_I && WB_ADR_I == VBIT_OFS && WB_SEL_I[0]);
   endsequence
   // mode shadow from bus writes
   always_comb
   begin
      next_raw = raw_q;
      if (WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_ADR_I == MODE_OFS)
         next_raw = WB_SEL_I[0] ? WB_DAT_I[RAW_BIT] : raw_q;
   end
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         raw_q <= 1'b0;
      else
         raw_q <= next_raw;
   end
   ack_after_req_a: assert property (req_s |=> WB_ACK_O)
      else $error("no ack after request");
   ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   dat_idle_zero_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data without ack");
   eav_sets_blank_a: assert property (EAV_INSERT |-> LINE_BLANK)
      else $error("eav without line blank");
   sav_fall_a: assert property ($fell(LINE_BLANK) && !raw_q |->
      SAV_INSERT || $past(SAV_INSERT, 4))
      else $error("blank fell away from sav");
   raw_no_codes_a: assert property (raw_q && $past(raw_q) |->
      !EAV_INSERT && !SAV_INSERT)
      else $error("code strobe in raw mode");
   vbit_set_a: assert property (vbit_wr_s ##0 WB_DAT_I[0] |-> ##[1:2] FIELD1_VBIT)
      else $error("v bit not set");
   vbit_clr_a: assert property (vbit_wr_s ##0 !WB_DAT_I[0] |-> ##[1:2] !FIELD1_VBIT)
      else $error("v bit not cleared");
endmodule
bind display_blanking_timing blanking_props u_props (.CORE_CLK(CORE_CLK), .RESET(RESET),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .LINE_BLANK(LINE_BLANK), .FRAME_BLANK(FRAME_BLANK), .EAV_INSERT(EAV_INSERT),
   .SAV_INSERT(SAV_INSERT), .FIELD1_VBIT(FIELD1_VBIT));

//--- tb/tb_top.sv
// self-checking bench for the display blanking timing block
// assumes a 25 MHz pixel clock and the register map of blank_pkg
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top
   import blank_pkg::*;
;
   logic        CORE_CLK, RESET, cyc, stb, we, ack, lb, fb, eav, sav, vbit;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, dat_o, q;
   int          mismatches, comparisons, hi, lo, c0, codes;
   display_blanking_timing dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .LINE_BLANK(lb), .FRAME_BLANK(fb),
      .EAV_INSERT(eav), .SAV_INSERT(sav), .FIELD1_VBIT(vbit));
   video_sink_model sink (.clk(CORE_CLK), .rst(RESET), .eav(eav), .sav(sav), .codes(codes));
   always #20 CORE_CLK = ~CORE_CLK;
   task end_sim;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do
      begin
         @(posedge CORE_CLK);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      if (n >= 50)
         mismatches++;
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK("read data", e, q)
   endtask
   // wait until the chosen blank output reaches v
   task wt(input int f, input logic v, output int n);
      n = 0;
      while ((f ? fb : lb) !== v && n < 300)
      begin
         @(negedge CORE_CLK);
         n++;
      end
   endtask
   task span(input int f);
      int n;
      @(negedge CORE_CLK);
      wt(f, 1'b0, n);
      wt(f, 1'b1, n);
      wt(f, 1'b0, hi);
      wt(f, 1'b1, lo);
   endtask
   initial
   begin
      #400000;
      mismatches++;
      end_sim;
   end
   initial
   begin
      CORE_CLK = 1'b0;
      RESET = 1'b1;
      {cyc, stb, we} = 3'h0;
      adr = 8'h00;
      sel = 4'hF;
      dat = 32'h0;
      mismatches = 0;
      comparisons = 0;
      repeat (12) @(posedge CORE_CLK);
      RESET <= 1'b0;
      rd(HBLANK_OFS, REG_RESET);
      rd(VBLANK_OFS, REG_RESET);
      rd(STATUS_OFS, 32'h00018000);
      wb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
      rd(STATUS_OFS, 32'h00018000);
      wb(1'b1, HBLANK_OFS, 32'hFFFFFFFF);
      rd(HBLANK_OFS, HBLANK_MASK);
      wb(1'b1, VBLANK_OFS, 32'hFFFFFFFF);
      rd(VBLANK_OFS, POS_MASK);
      sel <= 4'h3;
      wb(1'b1, VBLANK_OFS, 32'h00000000);
      sel <= 4'hF;
      rd(VBLANK_OFS, 32'h0FFF0000);
      rd(8'h20, REG_RESET);
      wb(1'b1, FRAME_OFS, 32'h00030014);
      wb(1'b1, VBLANK_OFS, 32'h00020007);
      wb(1'b1, MODE_OFS, 32'h00000000);
      wb(1'b1, HBLANK_OFS, 32'h000A0005);
      span(0);
      `CHK("blank width", 5, hi)
      `CHK("line period", 20, hi + lo)
      wb(1'b1, HBLANK_OFS, 32'h000A8005);
      for (int m = 0; m < 8; m += 2)
      begin
         wb(1'b1, MODE_OFS, 32'(m));
         span(0);
         `CHK("delayed width", m[1] ? 5 : 9, hi)
         c0 = codes;
         repeat (60) @(negedge CORE_CLK);
         `CHK("code count", m[1] ? 0 : 6, codes - c0)
      end
      span(1);
      `CHK("frame blank", 32, hi)
      `CHK("frame period", 60, hi + lo)
      wb(1'b1, VBIT_OFS, 32'h1);
      repeat (2) @(negedge CORE_CLK);
      `CHK("v bit", 1'b1, vbit)
      wb(1'b1, VBIT_OFS, 32'h0);
      repeat (2) @(negedge CORE_CLK);
      `CHK("v bit", 1'b0, vbit)
      end_sim;
   end
endmodule

//--- tb/video_sink_model.sv
// display side model: counts eav and sav code strobes
// assumes strobes are one-cycle pulses on the pixel clock
`timescale 1ns/1ps
module video_sink_model
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic eav,
   input  wire logic sav,
   output int        codes
);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         codes <= 0;
      else
         codes <= codes + int'(eav) + int'(sav);
   end
endmodule
